//--- inc/quick_logic_pkg.sv
// Constants for the add-quick / add-with-extend / logical AND decode-execute block.
// Assumes a 32-bit Avalon-MM register port with byte addresses and one core clock.
package quick_logic_pkg;
   // Register byte offsets
   localparam logic [4:0] REG_OPCODE = 5'h00;
   localparam logic [4:0] REG_EXT    = 5'h04;
   localparam logic [4:0] REG_SRC    = 5'h08;
   localparam logic [4:0] REG_DST    = 5'h0C;
   localparam logic [4:0] REG_CCR    = 5'h10;
   localparam logic [4:0] REG_CTRL   = 5'h14;
   localparam logic [4:0] REG_RESULT = 5'h18;
   localparam logic [4:0] REG_STATUS = 5'h1C;
   localparam int ADDR_W = 5;

   // Flag positions in the condition register
   localparam int CCR_C = 0;
   localparam int CCR_V = 1;
   localparam int CCR_Z = 2;
   localparam int CCR_N = 3;
   localparam int CCR_X = 4;
   localparam logic [4:0]  CCR_RESET    = 5'h00;
   localparam logic [15:0] OPCODE_RESET = 16'h0000;
   localparam logic [31:0] WORD_RESET   = 32'h00000000;

   // Control bits
   localparam int CTRL_GO       = 0;
   localparam int CTRL_CLR_DONE = 1;

   // Status field positions
   localparam int ST_DONE      = 0;
   localparam int ST_LEGAL     = 1;
   localparam int ST_KIND      = 2;
   localparam int ST_SIZE      = 5;
   localparam int ST_DEST_DATA = 7;
   localparam int ST_DEST_PTR  = 8;
   localparam int ST_DEST_EA   = 9;
   localparam int ST_PREDEC    = 10;
   localparam int ST_IMM_WORDS = 11;
   localparam int ST_RX        = 13;
   localparam int ST_RY        = 16;
   localparam int ST_EA_MODE   = 19;
   localparam int ST_EA_REG    = 22;

   // Size codes
   localparam logic [1:0] SZ_BYTE = 2'b00;
   localparam logic [1:0] SZ_WORD = 2'b01;
   localparam logic [1:0] SZ_LONG = 2'b10;
   localparam logic [1:0] SZ_BAD  = 2'b11;

   // Effective-address mode and register codes
   localparam logic [2:0] MODE_DATA  = 3'h0;
   localparam logic [2:0] MODE_PTR   = 3'h1;
   localparam logic [2:0] MODE_IND   = 3'h2;
   localparam logic [2:0] MODE_INDEX = 3'h6;
   localparam logic [2:0] MODE_EXT   = 3'h7;
   localparam logic [2:0] EXT_ABS_W  = 3'h0;
   localparam logic [2:0] EXT_ABS_L  = 3'h1;
   localparam logic [2:0] EXT_PC_IDX = 3'h3;
   localparam logic [2:0] EXT_IMM    = 3'h4;

   // Fixed opcode bits
   localparam logic [3:0] TOP_ADD_QUICK = 4'h5;
   localparam logic [3:0] TOP_ADD_EXT   = 4'hD;
   localparam logic [3:0] TOP_AND_REG   = 4'hC;
   localparam logic [7:0] TOP_MASK_IMM  = 8'h02;

   typedef enum logic [2:0] {
      OP_NONE,
      OP_ADD_QUICK,
      OP_ADD_WITH_EXTEND,
      OP_AND_REG,
      OP_MASK_IMM
   } op_kind_t;
endpackage : quick_logic_pkg

//--- rtl/add_quick_extend_logic_ops.sv
// Decode and execute for add-quick, add-with-extend, register AND and AND-immediate.
// Software loads opcode, extension words and operands over Avalon-MM, then pulses go.
// Assumes one core clock; operand fetch and effective-address arithmetic happen outside.
//
// Function
// - Three-bit quick data means 1 to 7 as is, zero means eight.
// - Size field 00 byte, 01 word, 10 long.
// - Add-quick to pointer register allowed for word and long only.
// - Add-quick to pointer register uses all 32 bits, flags unchanged.
// - Add-quick elsewhere sets C, V, N, Z from the sum; X copies C.
// - Add-quick destination modes 000-110, or 111 with register 000/001.
// - Add-with-extend stores source plus destination plus X at chosen size.
// - Operand-mode bit 0 register to register, 1 memory with predecrement.
// - Destination field names destination, source field names source register.
// - Add-with-extend clears Z only on nonzero; sets C, V, N; X copies C.
// - Register AND conjoins source and destination; never a pointer register.
// - Both AND forms keep X, set N and Z, clear V and C.
// - AND opmodes 000-010 write data register, 100-110 write effective address.
// - AND source accepts data modes incl. immediate and PC-relative, not pointer.
// - AND destination accepts memory-alterable modes only.
// - AND data-register destination only via result-to-register opmodes.
// - AND-immediate conjoins immediate with destination, immediate at operation size.
// - Immediate: byte is low byte of one word, word one word, long two words.
// - AND-immediate accepts data-alterable destinations only.
`timescale 1ns/100ps
`default_nettype none
module add_quick_extend_logic_ops
   import quick_logic_pkg::*;
(
   input  wire logic                              ref_clk,
   input  wire logic                              sys_rst,
   input  wire logic [quick_logic_pkg::ADDR_W-1:0] address,
   input  wire logic                              read,
   input  wire logic                              write,
   input  wire logic [31:0]                       writedata,
   input  wire logic [3:0]                        byteenable,
   output logic      [31:0]                       readdata,
   output logic                                   waitrequest
);
   import quick_logic_pkg::*;

   function automatic logic [31:0] size_mask(input logic [1:0] sz);
      case (sz)
         SZ_BYTE: size_mask = 32'h000000FF;
         SZ_WORD: size_mask = 32'h0000FFFF;
         default: size_mask = 32'hFFFFFFFF;
      endcase
   endfunction : size_mask

   function automatic logic sign_bit(input logic [31:0] v, input logic [1:0] sz);
      case (sz)
         SZ_BYTE: sign_bit = v[7];
         SZ_WORD: sign_bit = v[15];
         default: sign_bit = v[31];
      endcase
   endfunction : sign_bit

   // Upper bits of the destination survive a narrow operation
   function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nv,
                                         input logic [1:0] sz);
      merge = (old & ~size_mask(sz)) | (nv & size_mask(sz));
   endfunction : merge

   // Returns {carry, overflow, sum}
   function automatic logic [33:0] add_sized(input logic [31:0] a, input logic [31:0] b,
                                             input logic cin, input logic [1:0] sz);
      logic [32:0] full;
      logic [31:0] am;
      logic [31:0] bm;
      logic        c;
      logic        v;
      am   = a & size_mask(sz);
      bm   = b & size_mask(sz);
      full = {1'b0, am} + {1'b0, bm} + {32'h00000000, cin};
      case (sz)
         SZ_BYTE: c = full[8];
         SZ_WORD: c = full[16];
         default: c = full[32];
      endcase
      v = (sign_bit(am, sz) == sign_bit(bm, sz)) && (sign_bit(full[31:0], sz) != sign_bit(am, sz));
      add_sized = {c, v, full[31:0]};
   endfunction : add_sized

   function automatic logic [31:0] apply_be(input logic [31:0] old, input logic [31:0] nv,
                                            input logic [3:0] be);
      apply_be = {be[3] ? nv[31:24] : old[31:24], be[2] ? nv[23:16] : old[23:16],
                  be[1] ? nv[15:8] : old[15:8], be[0] ? nv[7:0] : old[7:0]};
   endfunction : apply_be

   logic [15:0] opcode_r;
   logic [31:0] ext_r;
   logic [31:0] src_r;
   logic [31:0] dst_r;
   logic [31:0] result_r;
   logic [4:0]  ccr_r;
   logic        done_r;
   logic        waitrequest_r;
   logic [31:0] readdata_r;

   // Bus handshake: one wait cycle, then a single acknowledge cycle
   wire         req      = read | write;
   wire         accept   = req & ~waitrequest_r;
   wire         wr_take  = write & accept;
   wire [31:0]  wr_word  = apply_be(32'h00000000, writedata, byteenable);

   // Instruction fields
   wire [3:0]   top      = opcode_r[15:12];
   wire [2:0]   rx       = opcode_r[11:9];
   wire         bit8     = opcode_r[8];
   wire [1:0]   size     = opcode_r[7:6];
   wire [2:0]   opmode   = opcode_r[8:6];
   wire [2:0]   ea_mode  = opcode_r[5:3];
   wire [2:0]   ea_reg   = opcode_r[2:0];
   wire         rm       = opcode_r[3];
   wire [1:0]   and_size = opmode[1:0];
   wire         and_to_ea = opmode[2];

   wire is_add_quick = (top == TOP_ADD_QUICK) && !bit8 && (size != SZ_BAD);
   wire is_add_ext   = (top == TOP_ADD_EXT) && bit8 && (opcode_r[5:4] == 2'b00)
                       && (size != SZ_BAD);
   wire is_and_reg   = (top == TOP_AND_REG) && (and_size != SZ_BAD);
   wire is_mask_imm  = (opcode_r[15:8] == TOP_MASK_IMM) && (size != SZ_BAD);

   wire op_kind_t kind = is_add_quick ? OP_ADD_QUICK :
                         is_add_ext   ? OP_ADD_WITH_EXTEND :
                         is_and_reg   ? OP_AND_REG :
                         is_mask_imm  ? OP_MASK_IMM : OP_NONE;

   wire [1:0] op_size = (kind == OP_AND_REG) ? and_size : size;

   // Effective-address classes
   wire ea_abs     = (ea_mode == MODE_EXT) && (ea_reg == EXT_ABS_W || ea_reg == EXT_ABS_L);
   wire ea_mem_alt = ((ea_mode >= MODE_IND) && (ea_mode <= MODE_INDEX)) || ea_abs;
   wire ea_data_src = (ea_mode == MODE_DATA) || ((ea_mode >= MODE_IND) && (ea_mode <= MODE_INDEX))
                      || ((ea_mode == MODE_EXT) && (ea_reg <= EXT_IMM));
   wire ea_is_ptr  = (ea_mode == MODE_PTR);
   wire ea_is_imm  = (ea_mode == MODE_EXT) && (ea_reg == EXT_IMM);

   wire legal_add_quick = ea_mem_alt || (ea_mode == MODE_DATA)
                          || (ea_is_ptr && (size != SZ_BYTE));
   wire legal_and_reg   = and_to_ea ? ea_mem_alt
                                    : ea_data_src;
   wire legal_mask_imm  = ea_mem_alt || (ea_mode == MODE_DATA);

   wire legal = (kind == OP_ADD_QUICK)       ? legal_add_quick :
                (kind == OP_ADD_WITH_EXTEND) ? 1'b1 :
                (kind == OP_AND_REG)         ? legal_and_reg :
                (kind == OP_MASK_IMM)        ? legal_mask_imm : 1'b0;

   // Immediate data taken from the extension words
   wire [31:0] imm_val = (op_size == SZ_BYTE) ? {24'h000000, ext_r[23:16]} :
                         (op_size == SZ_WORD) ? {16'h0000, ext_r[31:16]} : ext_r;
   wire        uses_imm = (kind == OP_MASK_IMM) || ((kind == OP_AND_REG) && !and_to_ea && ea_is_imm);
   wire [1:0]  imm_words = !uses_imm ? 2'h0 : (op_size == SZ_LONG) ? 2'h2 : 2'h1;

   wire [31:0] quick_val = {28'h0000000, (rx == 3'h0), rx};

   // Destination routing
   wire dest_ptr  = (kind == OP_ADD_QUICK) && ea_is_ptr;
   wire dest_data = ((kind == OP_ADD_WITH_EXTEND) && !rm)
                    || ((kind == OP_AND_REG) && !and_to_ea)
                    || ((kind != OP_AND_REG) && (kind != OP_ADD_WITH_EXTEND) && (kind != OP_NONE)
                        && (ea_mode == MODE_DATA));
   wire dest_ea   = (kind != OP_NONE) && !dest_ptr && !dest_data;
   wire predec    = (kind == OP_ADD_WITH_EXTEND) && rm;

   // Arithmetic
   wire        is_quick = (kind == OP_ADD_QUICK);
   wire [31:0] add_b    = is_quick ? quick_val : src_r;
   wire        add_cin  = is_quick ? 1'b0 : ccr_r[CCR_X];
   wire [33:0] add_out  = add_sized(dst_r, add_b, add_cin, op_size);
   wire [31:0] add_sum  = merge(dst_r, add_out[31:0], op_size);
   wire        add_c    = add_out[33];
   wire        add_v    = add_out[32];
   wire        add_zero = ((add_out[31:0] & size_mask(op_size)) == 32'h00000000);
   wire [31:0] ptr_sum  = dst_r + quick_val;

   wire [31:0] and_src  = uses_imm ? imm_val : src_r;
   wire [31:0] and_raw  = and_src & dst_r;
   wire [31:0] and_res  = merge(dst_r, and_raw, op_size);
   wire        and_zero = ((and_raw & size_mask(op_size)) == 32'h00000000);

   wire [4:0] ccr_add_quick = {add_c, sign_bit(add_out[31:0], op_size), add_zero, add_v, add_c};
   wire [4:0] ccr_add_ext   = {add_c, sign_bit(add_out[31:0], op_size),
                               add_zero & ccr_r[CCR_Z], add_v, add_c};
   wire [4:0] ccr_and       = {ccr_r[CCR_X], sign_bit(and_raw, op_size), and_zero,
                               1'b0, 1'b0};

   wire [31:0] exec_res = dest_ptr ? ptr_sum :
                          (kind == OP_AND_REG || kind == OP_MASK_IMM) ? and_res : add_sum;
   wire [4:0]  exec_ccr = dest_ptr ? ccr_r :
                          (kind == OP_ADD_QUICK)       ? ccr_add_quick :
                          (kind == OP_ADD_WITH_EXTEND) ? ccr_add_ext : ccr_and;

   // Control register write
   wire ctrl_wr   = wr_take && (address == REG_CTRL);
   wire go        = ctrl_wr && byteenable[0] && writedata[CTRL_GO];
   wire clr_done  = ctrl_wr && byteenable[0] && writedata[CTRL_CLR_DONE];
   wire exec_ok   = go && legal;

   // Live decode of the held opcode, top bits reserved
   wire [31:0] status = {7'h00,
                         ea_reg,
                         ea_mode,
                         (kind == OP_ADD_WITH_EXTEND) ? opcode_r[2:0] : 3'h0,
                         rx,
                         imm_words,
                         predec,
                         dest_ea,
                         dest_ptr,
                         dest_data,
                         op_size,
                         kind,
                         legal,
                         done_r};

   logic [31:0] rd_mux;
   always_comb begin
      case (address)
         REG_OPCODE: rd_mux = {16'h0000, opcode_r};
         REG_EXT:    rd_mux = ext_r;
         REG_SRC:    rd_mux = src_r;
         REG_DST:    rd_mux = dst_r;
         REG_CCR:    rd_mux = {27'h0000000, ccr_r};
         REG_RESULT: rd_mux = result_r;
         REG_STATUS: rd_mux = status;
         default:    rd_mux = 32'h00000000;
      endcase
   end

   wire [31:0] opcode_wide = apply_be({16'h0000, opcode_r}, writedata, byteenable);
   wire [31:0] ccr_wide    = apply_be({27'h0000000, ccr_r}, wr_word, byteenable);

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         waitrequest_r <= 1'b1;
         readdata_r    <= WORD_RESET;
      end else begin
         waitrequest_r <= ~(req & waitrequest_r);
         if (req && waitrequest_r) begin
            readdata_r <= rd_mux;
         end
      end
   end

   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         opcode_r <= OPCODE_RESET;
         ext_r    <= WORD_RESET;
         src_r    <= WORD_RESET;
         dst_r    <= WORD_RESET;
      end else if (wr_take) begin
         if (address == REG_OPCODE) opcode_r <= opcode_wide[15:0];
         if (address == REG_EXT)    ext_r    <= apply_be(ext_r, writedata, byteenable);
         if (address == REG_SRC)    src_r    <= apply_be(src_r, writedata, byteenable);
         if (address == REG_DST)    dst_r    <= apply_be(dst_r, writedata, byteenable);
      end
   end

   // Execution wins over a software write to the flags in the same cycle
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         ccr_r    <= CCR_RESET;
         result_r <= WORD_RESET;
      end else if (exec_ok) begin
         ccr_r    <= exec_ccr;
         result_r <= exec_res;
      end else if (wr_take && (address == REG_CCR)) begin
         ccr_r    <= ccr_wide[4:0];
      end
   end

   // Set beats clear
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         done_r <= 1'b0;
      end else if (go) begin
         done_r <= 1'b1;
      end else if (clr_done) begin
         done_r <= 1'b0;
      end
   end

   assign readdata    = readdata_r;
   assign waitrequest = waitrequest_r;
endmodule : add_quick_extend_logic_ops
`default_nettype wire

//--- bench/add_quick_extend_logic_ops_properties.sv
// Checker for the bus handshake and the live decode status of the block.
// Assumes full-word writes to the opcode register while its shadow is used.
`timescale 1ns/100ps
`default_nettype none
module add_quick_extend_logic_ops_properties
   import quick_logic_pkg::*;
(
   input wire logic                               ref_clk,
   input wire logic                               sys_rst,
   input wire logic [quick_logic_pkg::ADDR_W-1:0] address,
   input wire logic                               read,
   input wire logic                               write,
   input wire logic [31:0]                        writedata,
   input wire logic [3:0]                         byteenable,
   input wire logic [31:0]                        readdata,
   input wire logic                               waitrequest
);
   logic [15:0] op_r;
   wire         ack = read && !waitrequest && address == REG_STATUS;
   wire  [2:0]  md  = op_r[5:3];
   wire  [2:0]  rg  = op_r[2:0];
   wire  [1:0]  sz  = op_r[7:6];
   wire         alt = md != MODE_EXT || rg < 3'h2;
   wire         aq  = op_r[15:12] == TOP_ADD_QUICK && !op_r[8] && sz != SZ_BAD;
   wire         ax  = op_r[15:12] == TOP_ADD_EXT && op_r[8] && op_r[5:4] == 2'h0 && sz != SZ_BAD;
   wire         an  = op_r[15:12] == TOP_AND_REG && sz != SZ_BAD;
   wire         mi  = op_r[15:8] == TOP_MASK_IMM && sz != SZ_BAD;
   wire  [2:0]  kd  = aq ? OP_ADD_QUICK : ax ? OP_ADD_WITH_EXTEND : an ? OP_AND_REG : mi ? OP_MASK_IMM : OP_NONE;
   // Shadow of the opcode so the live status can be judged
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         op_r <= OPCODE_RESET;
      end else if (write && !waitrequest && address == REG_OPCODE) begin
         op_r <= writedata[15:0];
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);
   chk_wait_answer: assert property ((read || write) && waitrequest |=> !waitrequest ##1 waitrequest)
      else $error("waitrequest not low for exactly one cycle");
   chk_kind_code: assert property (ack |-> readdata[ST_KIND +: 3] == kd && (kd != 3'h0 || !readdata[ST_LEGAL]))
      else $error("status kind wrong");
   chk_size_field: assert property (ack && (aq || ax || mi) |-> readdata[ST_SIZE +: 2] == sz)
      else $error("status size wrong");
   chk_quick_legal: assert property (ack && aq |->
      readdata[ST_LEGAL] == (alt && !(md == MODE_PTR && sz == SZ_BYTE)))
      else $error("add-quick legality wrong");
   chk_and_src: assert property (ack && an && !op_r[8] |->
      readdata[ST_LEGAL] == (md != MODE_PTR && (md != MODE_EXT || rg <= EXT_IMM)))
      else $error("and source legality wrong");
   chk_and_dst: assert property (ack && an && op_r[8] |-> readdata[ST_LEGAL] == (md >= MODE_IND && alt))
      else $error("and destination legality wrong");
   chk_imm_legal: assert property (ack && mi |-> readdata[ST_LEGAL] == (md != MODE_PTR && alt))
      else $error("and-immediate legality wrong");
   chk_imm_words: assert property (ack && mi |-> readdata[ST_IMM_WORDS +: 2] == (sz == SZ_LONG ? 2'h2 : 2'h1))
      else $error("immediate word count wrong");
   chk_extend_fields: assert property (ack && ax |-> readdata[ST_LEGAL] && readdata[ST_PREDEC] == op_r[3]
      && readdata[ST_RX +: 3] == op_r[11:9] && readdata[ST_RY +: 3] == rg)
      else $error("add-with-extend fields wrong");
endmodule : add_quick_extend_logic_ops_properties
bind add_quick_extend_logic_ops add_quick_extend_logic_ops_properties chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
   .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
   .readdata(readdata), .waitrequest(waitrequest));
`default_nettype wire

//--- bench/add_quick_extend_logic_ops_tb_top.sv
// Self-checking bench: runs instructions through the register port and checks results.
// Assumes the one-wait-state Avalon-MM slave timing of the register port.
`timescale 1ns/100ps
`default_nettype none
`define check_eq(nm, e, g) begin n_tests++; if ((g) !== (e)) begin num_errors++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module add_quick_extend_logic_ops_tb_top;
   import quick_logic_pkg::*;
   typedef struct { string nm; logic [31:0] val; logic [31:0] msk; } note_t;
   logic              ref_clk, sys_rst, read, write, waitrequest;
   logic [ADDR_W-1:0] address;
   logic [31:0]       writedata, readdata;
   logic [31:0]       lfsr_r = 32'hA1F4;
   logic [3:0]        byteenable;
   int                num_errors, n_tests, cycles;
   note_t             notes[$];
   note_t             nt;
   logic [15:0]       ill_op [9] = '{16'h5609, 16'h52BC, 16'hC288, 16'hC23D, 16'hC342, 16'hC3BC, 16'h0248,
                                     16'h023A, 16'h5140};
   op_kind_t          ill_kd [9] = '{OP_ADD_QUICK, OP_ADD_QUICK, OP_AND_REG, OP_AND_REG, OP_AND_REG,
                                     OP_AND_REG, OP_MASK_IMM, OP_MASK_IMM, OP_NONE};
   add_quick_extend_logic_ops dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
      .waitrequest(waitrequest));
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] rnd();
      lfsr_r = {lfsr_r[30:0], lfsr_r[31] ^ lfsr_r[21] ^ lfsr_r[1] ^ lfsr_r[0]};
      return lfsr_r;
   endfunction : rnd
   function automatic int wd(logic [1:0] sz);
      return sz == SZ_BYTE ? 8 : sz == SZ_WORD ? 16 : 32;
   endfunction : wd
   // Returns carry, overflow, negative, zero, merged result
   function automatic logic [35:0] addf(logic [31:0] d, s, logic ci, logic [1:0] sz);
      logic [32:0] t;
      logic [31:0] m;
      m = wd(sz) == 32 ? 32'hFFFFFFFF : (32'h1 << wd(sz)) - 32'h1;
      t = {1'b0, d & m} + {1'b0, s & m} + {32'h0, ci};
      return {t[wd(sz)], d[wd(sz)-1] == s[wd(sz)-1] && t[wd(sz)-1] != d[wd(sz)-1], t[wd(sz)-1],
              (t[31:0] & m) == 32'h0, (d & ~m) | (t[31:0] & m)};
   endfunction : addf
   function automatic logic [33:0] andf(logic [31:0] d, s, logic [1:0] sz);
      logic [31:0] r;
      r = d & s & (wd(sz) == 32 ? 32'hFFFFFFFF : (32'h1 << wd(sz)) - 32'h1);
      return {r[wd(sz)-1], r == 32'h0, (d & ~(wd(sz) == 32 ? 32'hFFFFFFFF : (32'h1 << wd(sz)) - 32'h1)) | r};
   endfunction : andf
   function automatic logic [31:0] st(op_kind_t k, logic l);
      return {27'h0, k, l, 1'b1};
   endfunction : st
   task automatic complete_run();
      $display("Comparisons %0d, mismatches %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : complete_run
   task automatic bus(logic rd, logic [4:0] a, logic [31:0] d, logic [3:0] be);
      @(posedge ref_clk);
      address <= a;
      read <= rd;
      write <= !rd;
      writedata <= d;
      byteenable <= be;
      do @(posedge ref_clk); while (waitrequest !== 1'b0);
      read <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task automatic wr(logic [4:0] a, logic [31:0] d);
      bus(1'b0, a, d, 4'hF);
   endtask : wr
   task automatic rd(string nm, logic [4:0] a, logic [31:0] e, logic [31:0] m);
      notes.push_back('{nm, e, m});
      bus(1'b1, a, 32'h0, 4'hF);
   endtask : rd
   task automatic run(logic [15:0] op, logic [31:0] ext, src, dst, logic [4:0] cc, logic [31:0] res,
                      logic [4:0] ecc, logic [31:0] est);
      wr(REG_OPCODE, {16'h0, op});
      wr(REG_EXT, ext);
      wr(REG_SRC, src);
      wr(REG_DST, dst);
      wr(REG_CCR, {27'h0, cc});
      wr(REG_CTRL, 32'h1);
      rd("result", REG_RESULT, res, 32'hFFFFFFFF);
      rd("ccr", REG_CCR, {27'h0, ecc}, 32'hFFFFFFFF);
      rd("status", REG_STATUS, est, 32'h1F);
   endtask : run
   // Result watcher: the oldest note is due at each read acknowledge
   always @(posedge ref_clk) begin
      cycles++;
      if (cycles == 6000) begin
         num_errors++;
         complete_run();
      end
      if (read === 1'b1 && waitrequest === 1'b0) begin
         nt = notes.pop_front();
         `check_eq(nt.nm, nt.val & nt.msk, readdata & nt.msk)
      end
   end
   initial begin
      logic [35:0] a;
      logic [33:0] b;
      logic [31:0] d, s, e;
      logic [4:0]  c;
      logic [1:0]  sz;
      sys_rst = 1'b1;
      read = 1'b0;
      write = 1'b0;
      address = 5'h00;
      writedata = 32'h0;
      byteenable = 4'hF;
      repeat (6) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd("status", REG_STATUS, 32'h0, 32'hFFFFFFFF);
      wr(REG_RESULT, 32'hFFFFFFFF);
      rd("result", REG_RESULT, 32'h0, 32'hFFFFFFFF);
      rd("gap", 5'h02, 32'h0, 32'hFFFFFFFF);
      wr(REG_DST, 32'hAAAAAAAA);
      bus(1'b0, REG_DST, 32'h55555555, 4'h2);
      rd("dst", REG_DST, 32'hAAAA55AA, 32'hFFFFFFFF);
      for (int i = 0; i < 8; i++) begin
         sz = 2'(i % 3);
         d = i == 0 ? 32'hABCDEFF8 : i == 6 ? 32'h1234567F : rnd();
         a = addf(d, i == 0 ? 32'h8 : i, 1'b0, sz);
         run({4'h5, 3'(i), 1'b0, sz, MODE_DATA, 3'h2}, 32'h0, rnd(), d, rnd(), a[31:0],
             {a[35], a[33], a[32], a[34], a[35]}, st(OP_ADD_QUICK, 1'b1));
      end
      run({4'h5, 3'h3, 1'b0, SZ_WORD, MODE_PTR, 3'h1}, 32'h0, 32'h0, 32'h0000FFFF, 5'h15, 32'h00010002,
          5'h15, st(OP_ADD_QUICK, 1'b1));
      for (int i = 0; i < 4; i++) begin
         sz = 2'(i % 3);
         d = rnd();
         s = i >= 2 ? ~d : rnd();
         c = {1'b1, 1'b0, i[0], 2'h0};
         a = addf(d, s, 1'b1, sz);
         run({4'hD, 3'(i), 1'b1, sz, 2'h0, i[0], 3'h5}, 32'h0, s, d, c, a[31:0],
             {a[35], a[33], a[32] & c[2], a[34], a[35]}, st(OP_ADD_WITH_EXTEND, 1'b1));
      end
      for (int i = 0; i < 4; i++) begin
         sz = 2'(i % 3);
         d = rnd();
         s = i == 2 ? ~d : rnd();
         c = rnd();
         b = andf(d, s, sz);
         run({4'hC, 3'h2, i == 3, sz, i == 3 ? MODE_IND : i == 1 ? MODE_EXT : MODE_DATA, i == 1 ? EXT_PC_IDX : 3'h3},
             32'h0, s, d, c, b[31:0], {c[4], b[33], b[32], 2'h0}, st(OP_AND_REG, 1'b1));
      end
      d = rnd();
      b = andf(d, 32'h0000F0F0, SZ_WORD);
      run({4'hC, 3'h1, 1'b0, SZ_WORD, MODE_EXT, EXT_IMM}, 32'hF0F01234, rnd(), d, 5'h1F, b[31:0],
          {1'b1, b[33], b[32], 2'h0}, st(OP_AND_REG, 1'b1));
      for (int i = 0; i < 3; i++) begin
         sz = 2'(i);
         d = rnd();
         e = rnd();
         s = sz == SZ_BYTE ? {24'h0, e[23:16]} : sz == SZ_WORD ? {16'h0, e[31:16]} : e;
         c = rnd();
         b = andf(d, s, sz);
         run({TOP_MASK_IMM, sz, i == 0 ? MODE_DATA : MODE_IND, 3'h4}, e, rnd(), d, c, b[31:0],
             {c[4], b[33], b[32], 2'h0}, st(OP_MASK_IMM, 1'b1));
      end
      for (int i = 0; i < 9; i++) begin
         d = rnd();
         c = rnd();
         // Refused opcodes leave the last legal result in place
         run(ill_op[i], rnd(), rnd(), d, c, b[31:0], c, st(ill_kd[i], 1'b0));
      end
      wr(REG_CTRL, 32'h2);
      rd("done", REG_STATUS, 32'h0, 32'h1);
      wr(REG_CTRL, 32'h3);
      rd("done", REG_STATUS, 32'h1, 32'h1);
      repeat (2) @(posedge ref_clk);
      complete_run();
   end
endmodule : add_quick_extend_logic_ops_tb_top
`default_nettype wire
